// *** aicp_control_port.sv ***
module aicp_control_port (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // serial pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // straps
  input  wire logic [1:0] address_strap_disable_pin_i,
  input  wire logic       standby_silence_pin_i,
  // diagnostic results
  input  wire logic [31:0] diag_results_i,
  // control outputs
  output logic [7:0]      control_byte_one_o,
  output logic [7:0]      control_byte_two_o,
  output logic            bus_disabled_o,
  output logic            legacy_mode_o,
  output logic            diag_restart_o
);

  // ***************************************
  // synchronisers
  // ***************************************
  logic [1:0] scl_s, sda_s, next_scl_s, next_sda_s;
  logic       scl_d, sda_d;
  logic [1:0] strap_a, strap_b, next_strap_a;
  logic       stby_a, stby_b;

  always_comb begin
    next_scl_s   = {scl_s[0], scl_i};
    next_sda_s   = {sda_s[0], sda_i};
    next_strap_a = address_strap_disable_pin_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      scl_s   <= 2'h3;
      sda_s   <= 2'h3;
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      strap_a <= aicp_pkg::STRAP_OPEN;
      strap_b <= aicp_pkg::STRAP_OPEN;
      stby_a  <= 1'b0;
      stby_b  <= 1'b0;
    end else begin
      scl_s   <= next_scl_s;
      sda_s   <= next_sda_s;
      scl_d   <= scl_s[1];
      sda_d   <= sda_s[1];
      strap_a <= next_strap_a;
      strap_b <= strap_a;
      stby_a  <= standby_silence_pin_i;
      stby_b  <= stby_a;
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c, disabled;
  assign scl      = scl_s[1];
  assign sda      = sda_s[1];
  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start_c  = scl & scl_d & sda_d & ~sda;
  assign stop_c   = scl & scl_d & ~sda_d & sda;
  assign disabled = (strap_b == aicp_pkg::STRAP_OPEN);

  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    unique case (s)
      aicp_pkg::STRAP_GND:  strap_addr = aicp_pkg::ADDR_GND;
      aicp_pkg::STRAP_MID:  strap_addr = aicp_pkg::ADDR_MID;
      aicp_pkg::STRAP_HIGH: strap_addr = aicp_pkg::ADDR_HIGH;
      default:              strap_addr = aicp_pkg::ADDR_GND;
    endcase
  endfunction

  // ***************************************
  // protocol engine
  // ***************************************
  aicp_pkg::aicp_state_t state, next_state, ret, next_ret;
  logic [7:0]  shreg, next_shreg, b1, next_b1, b2, next_b2;
  logic [2:0]  bitc, next_bitc, bytec, next_bytec;
  logic        oe, next_oe, rd, next_rd, restart, next_restart, full, next_full;
  logic [31:0] snap, next_snap;

  always_comb begin
    next_state   = state;
    next_ret     = ret;
    next_shreg   = shreg;
    next_b1      = b1;
    next_b2      = b2;
    next_bitc    = bitc;
    next_bytec   = bytec;
    next_oe      = oe;
    next_rd      = rd;
    next_restart = 1'b0;
    next_full    = full;
    next_snap    = snap;
    if (disabled) begin
      next_state = aicp_pkg::AICP_IDLE;
      next_oe    = 1'b0;
    end else if (start_c) begin
      next_state = aicp_pkg::AICP_ADDR;
      next_bitc  = 3'h0;
      next_full  = 1'b0;
      next_oe    = 1'b0;
    end else if (stop_c) begin
      next_state = aicp_pkg::AICP_IDLE;
      next_oe    = 1'b0;
    end else begin
      unique case (state)
        aicp_pkg::AICP_IDLE, aicp_pkg::AICP_SKIP: begin
          next_oe = 1'b0;
        end
        aicp_pkg::AICP_ADDR, aicp_pkg::AICP_WRITE: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda};
            next_bitc  = bitc + 3'h1;
            next_full  = (bitc == 3'h7);
          end
          if (scl_fall && full) begin
            if (state == aicp_pkg::AICP_ADDR) begin
              if (shreg[7:1] != strap_addr(strap_b)) begin
                next_state = aicp_pkg::AICP_SKIP;
              end else begin
                next_rd    = shreg[0];
                next_bytec = 3'h0;
                next_oe    = 1'b1;
                next_state = aicp_pkg::AICP_ACK;
                next_ret   = shreg[0] ? aicp_pkg::AICP_READ : aicp_pkg::AICP_WRITE;
                if (shreg[0]) begin
                  next_snap    = diag_results_i;
                  next_restart = 1'b1;
                end
              end
            end else if (bytec < aicp_pkg::CTRL_BYTES) begin
              if (bytec == 3'h0) begin
                next_b1 = shreg;
              end else begin
                next_b2 = {shreg[7], 1'b0, shreg[5:0]};
              end
              next_bytec = bytec + 3'h1;
              next_oe    = 1'b1;
              next_state = aicp_pkg::AICP_ACK;
              next_ret   = aicp_pkg::AICP_WRITE;
            end else begin
              next_state = aicp_pkg::AICP_SKIP;
            end
          end
        end
        aicp_pkg::AICP_ACK: begin
          if (scl_fall) begin
            next_state = ret;
            next_bitc  = 3'h0;
            if (ret == aicp_pkg::AICP_READ) begin
              next_shreg = snap[31:24];
              next_oe    = ~snap[31];
            end else begin
              next_oe = 1'b0;
            end
          end
        end
        aicp_pkg::AICP_READ: begin
          // change data on clock fall only
          if (scl_fall) begin
            next_bitc = bitc + 3'h1;
            if (bitc == 3'h7) begin
              next_oe    = 1'b0;
              next_state = aicp_pkg::AICP_RACK;
              next_bytec = bytec + 3'h1;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe    = ~shreg[6];
            end
          end
        end
        aicp_pkg::AICP_RACK: begin
          if (scl_rise) begin
            if (sda || bytec == aicp_pkg::DIAG_BYTES) begin
              next_state = aicp_pkg::AICP_SKIP;
            end else begin
              next_snap = {snap[23:0], 8'h00};
              next_ret  = aicp_pkg::AICP_READ;
              next_state = aicp_pkg::AICP_ACK;
              next_oe   = 1'b0;
            end
          end
        end
        default: next_state = aicp_pkg::AICP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state   <= aicp_pkg::AICP_IDLE;
      ret     <= aicp_pkg::AICP_IDLE;
      shreg   <= 8'h00;
      b1      <= aicp_pkg::CTRL_ONE_RST;
      b2      <= aicp_pkg::CTRL_TWO_RST;
      bitc    <= 3'h0;
      bytec   <= 3'h0;
      oe      <= 1'b0;
      rd      <= 1'b0;
      restart <= 1'b0;
      full    <= 1'b0;
      snap    <= 32'h0000_0000;
    end else begin
      state   <= next_state;
      ret     <= next_ret;
      shreg   <= next_shreg;
      b1      <= next_b1;
      b2      <= next_b2;
      bitc    <= next_bitc;
      bytec   <= next_bytec;
      oe      <= next_oe;
      rd      <= next_rd;
      restart <= next_restart;
      full    <= next_full;
      snap    <= next_snap;
    end
  end

  // ***************************************
  // outputs
  // ***************************************
  logic [7:0] next_c1, next_c2;
  always_comb begin
    next_c1 = b1;
    next_c2 = b2;
    if (disabled) begin
      // pin straps set gain and efficiency
      next_c1 = 8'h00;
      next_c1[aicp_pkg::B1_GAIN_FRONT] = sda;
      next_c1[aicp_pkg::B1_GAIN_REAR]  = sda;
      next_c1[aicp_pkg::B1_UNMUTE_FR]  = stby_b;
      next_c1[aicp_pkg::B1_UNMUTE_RR]  = stby_b;
      next_c2 = 8'h00;
      next_c2[aicp_pkg::B2_HE_RIGHT] = scl;
      next_c2[aicp_pkg::B2_HE_LEFT]  = scl;
      next_c2[aicp_pkg::B2_RUN]      = stby_b;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      control_byte_one_o <= aicp_pkg::CTRL_ONE_RST;
      control_byte_two_o <= aicp_pkg::CTRL_TWO_RST;
      bus_disabled_o     <= 1'b1;
      legacy_mode_o      <= 1'b0;
      diag_restart_o     <= 1'b0;
    end else begin
      control_byte_one_o <= next_c1;
      control_byte_two_o <= next_c2;
      bus_disabled_o     <= disabled;
      legacy_mode_o      <= disabled;
      diag_restart_o     <= restart;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = oe;

  // ***************************************
  // checks
  // ***************************************
  sequence addr_acked_s;
    state == aicp_pkg::AICP_ADDR ##1 state == aicp_pkg::AICP_ACK;
  endsequence

  ack_drive_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    addr_acked_s |-> oe) else $error("ack not driven");
  foreign_addr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == aicp_pkg::AICP_SKIP |-> ##1 !oe) else $error("drive on skip");
  stable_high_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    scl && scl_d && !disabled |-> oe == $past(oe)) else $error("sda moved high");
  restart_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    restart |-> ##1 diag_restart_o) else $error("restart lost");
  reserved_bit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !disabled |-> ##1 !control_byte_two_o[6]) else $error("reserved set");
  disable_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    disabled |-> ##1 bus_disabled_o && !oe) else $error("bus not off");
  start_goes_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_c && !disabled |-> ##1 state == aicp_pkg::AICP_ADDR) else $error("no start");
  stop_goes_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    stop_c && !disabled |-> ##1 state == aicp_pkg::AICP_IDLE) else $error("no stop");

endmodule

// *** aicp_host_model.sv ***
module aicp_host_model (
  // clock for edge alignment
  input  wire logic clk_i,
  // bus lines
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real QTR = 31.25;
  // *****
  // master cycles
  // *****
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic start();
    // keep pin changes clear of sampling edges
    @(negedge clk_i);
    #2;
    #QTR sda_low_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_low_o = 1'b1;
    #QTR scl_o = 1'b0;
  endtask
  task automatic stop();
    #QTR sda_low_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_low_o = 1'b0;
    #QTR;
  endtask
  task automatic clk_bit(input logic b, output logic s);
    #QTR sda_low_o = !b;
    #QTR scl_o = 1'b1;
    #QTR s = sda_i;
    #QTR scl_o = 1'b0;
  endtask
  task automatic put(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, nack);
  endtask
  task automatic get(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(nack, s);
  endtask
  // static pin levels, bus off
  task automatic hold(input logic c, input logic d);
    scl_o = c;
    sda_low_o = !d;
  endtask
endmodule

// *** aicp_pkg.sv ***
package aicp_pkg;

  // ***************************************
  // strap decode and addresses
  // ***************************************
  localparam logic [1:0] STRAP_GND    = 2'h0;
  localparam logic [1:0] STRAP_MID    = 2'h1;
  localparam logic [1:0] STRAP_HIGH   = 2'h2;
  localparam logic [1:0] STRAP_OPEN   = 2'h3;
  localparam logic [6:0] ADDR_GND     = 7'h6C;
  localparam logic [6:0] ADDR_MID     = 7'h6D;
  localparam logic [6:0] ADDR_HIGH    = 7'h6E;

  // ***************************************
  // control byte fields
  // ***************************************
  localparam int B1_MUTE_THR   = 7;
  localparam int B1_DIAG_EN    = 6;
  localparam int B1_OFFSET_EN  = 5;
  localparam int B1_GAIN_FRONT = 4;
  localparam int B1_GAIN_REAR  = 3;
  localparam int B1_UNMUTE_FR  = 2;
  localparam int B1_UNMUTE_RR  = 1;
  localparam int B1_CLIP_THR   = 0;
  localparam int B2_CUR_THR    = 7;
  localparam int B2_FAST_MUTE  = 5;
  localparam int B2_RUN        = 4;
  localparam int B2_LINE_DIAG  = 3;
  localparam int B2_CUR_DIAG   = 2;
  localparam int B2_HE_RIGHT   = 1;
  localparam int B2_HE_LEFT    = 0;

  // ***************************************
  // reset values and counts
  // ***************************************
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [2:0] DIAG_BYTES   = 3'h4;
  localparam logic [2:0] CTRL_BYTES   = 3'h2;

  typedef enum logic [2:0] {
    AICP_IDLE  = 3'b000,
    AICP_ADDR  = 3'b001,
    AICP_WRITE = 3'b010,
    AICP_READ  = 3'b011,
    AICP_ACK   = 3'b100,
    AICP_RACK  = 3'b101,
    AICP_SKIP  = 3'b110
  } aicp_state_t;

endpackage

// *** amp_i2c_control_port_bench.sv ***
module amp_i2c_control_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, scl, sda_low, sda, sda_o, sda_oe, stby;
  logic        bus_off, legacy, restart;
  logic [1:0]  strap;
  logic [31:0] diag;
  logic [7:0]  cb1, cb2, b1, b2;
  logic [15:0] exp_q[$], got_q[$], e, g;
  logic [6:0]  own [3];
  int          fail_count, total_checks, rcnt;
  assign own = '{aicp_pkg::ADDR_GND, aicp_pkg::ADDR_MID, aicp_pkg::ADDR_HIGH};
  assign sda = (sda_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  aicp_control_port aicp_control_port_i (
    .clk_sys_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .address_strap_disable_pin_i(strap),
    .standby_silence_pin_i(stby), .diag_results_i(diag),
    .control_byte_one_o(cb1), .control_byte_two_o(cb2),
    .bus_disabled_o(bus_off), .legacy_mode_o(legacy), .diag_restart_o(restart));
  aicp_host_model aicp_host_model_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  // *****
  // clock, checker, watchdog
  // *****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rst) rcnt <= 0;
    else if (restart === 1'b1) rcnt <= rcnt + 1;
  end
  initial begin
    forever begin
      wait (got_q.size() > 0);
      g = got_q.pop_front();
      e = exp_q.pop_front();
      total_checks++;
      if (g !== e) begin
        fail_count++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  end
  initial begin
    #500000;
    fail_count++;
    complete_run();
  end
  task automatic complete_run();
    $display("mismatches %0d, checks %0d", fail_count, total_checks);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic note(input logic [15:0] v);
    exp_q.push_back(v);
  endtask
  task automatic seen(input logic [15:0] v);
    got_q.push_back(v);
  endtask
  // *****
  // transfers
  // *****
  task automatic wr(input logic [6:0] a, input logic [3:0] nk, input logic extra);
    logic [3:0] k;
    note({12'h000, nk});
    aicp_host_model_i.start();
    aicp_host_model_i.put({a, 1'b0}, k[3]);
    aicp_host_model_i.put(b1, k[2]);
    aicp_host_model_i.put(b2, k[1]);
    k[0] = nk[0];
    if (extra) aicp_host_model_i.put(8'hA5, k[0]);
    aicp_host_model_i.stop();
    seen({12'h000, k});
  endtask
  task automatic rd(input logic [6:0] a, input logic nk);
    logic       k;
    logic [7:0] d;
    int         r0;
    r0 = rcnt;
    note({15'h0000, nk});
    aicp_host_model_i.start();
    aicp_host_model_i.put({a, 1'b1}, k);
    seen({15'h0000, k});
    for (int i = 0; i < 4; i++) begin
      if (!nk) note({8'h00, diag[31-8*i -: 8]});
      aicp_host_model_i.get(i == 3, d);
      if (!nk) seen({8'h00, d});
    end
    aicp_host_model_i.stop();
    note(16'(r0 + (nk ? 0 : 1)));
    seen(16'(rcnt));
  endtask
  // *****
  // scenarios
  // *****
  initial begin
    void'($urandom(32'h8781));
    rst = 1'b1;
    strap = aicp_pkg::STRAP_GND;
    stby = 1'b0;
    diag = 32'h0000_0000;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    note(16'h0000);
    seen({cb1, cb2});
    for (int s = 0; s < 3; s++) begin
      @(negedge clk);
      strap = 2'(s);
      diag = $urandom;
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      repeat (10) @(negedge clk);
      note(16'h0000);
      seen({14'h0000, bus_off, legacy});
      wr(own[s], 4'h0, 1'b0);
      note({b1, b2 & 8'hBF});
      seen({cb1, cb2});
      b1 = ~b1;
      b2 = ~b2;
      wr(own[s] ^ 7'h01, 4'hF, 1'b0);
      note(~{b1, b2} & 16'hFFBF);
      seen({cb1, cb2});
      rd(own[s], 1'b0);
      rd(own[s] ^ 7'h02, 1'b1);
    end
    b1 = 8'hFF;
    b2 = 8'hFF;
    wr(own[2], 4'h1, 1'b1);
    note(16'hFFBF);
    seen({cb1, cb2});
    @(negedge clk);
    strap = aicp_pkg::STRAP_OPEN;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      stby = i[0];
      aicp_host_model_i.hold(i[1], i[2]);
      repeat (10) @(negedge clk);
      note({3'h0, i[2], i[2], i[0], i[0], 4'h0, i[0], 2'h0, i[1], i[1]});
      seen({cb1, cb2} & 16'h1E13);
    end
    note(16'h0003);
    seen({14'h0000, bus_off, legacy});
    aicp_host_model_i.hold(1'b1, 1'b1);
    wr(own[0], 4'hF, 1'b0);
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule
